// ---- vplc_pkg.sv ----
// Constants, encodings and carrier types of the video port reset and lane control block
// Overview of operation
// RULE1: 8-bit BT.656 and 8-bit raw capture: channel A lanes 9..2, B lanes 19..12.
// RULE2: Y/C capture luma 9..2, chroma 19..12; 16-bit raw all lanes (code takes only 19..12 and 9..2); transport 9..2.
// RULE3: Display: BT.656 on 9..2; Y/C and 16-bit both halves; dual sync adds B.
// RULE4: Software selects the shared pins for the video port before use.
// RULE5: Software enables the module clock before any data transfer.
// RULE6: Power-on reset acts asynchronously and floats data, control and capture clock pins.
// RULE7: Bus reset is synchronous and may be held to keep the port disabled.
// RULE8: Bus reset floats pins, defaults all registers, clears enable, sets halt.
// RULE9: Register reset completes only on edges of the module clocks.
// RULE10: With enable clear, video clocks and system time clock are gated off.
// RULE11: Every bus access is acknowledged, even while disabled or halted.
// RULE12: With enable clear only the GPIO group is accessible; all once set.
// RULE13: While disabled or halted, pins float unless enabled as GPIO.
// RULE14: Enable set with halt set runs clocks; port control stays writable.
// RULE15: Soft reset resets port logic except enable, self-clears on capture clock, keeps halt.
// RULE16: Software polls the soft reset bit clear before writing port registers.
// RULE17: After halt clears only soft reset is settable; display clock may drive.
// RULE18: Control pins stay floating after halt release unless used as GPIO.
// RULE19: Channel reset affects only its channel and waits for that channel clock.
// RULE20: Channel reset stops capture, defaults registers, clears enable, then self-clears.
// RULE21: With capture enabled only enable, reset and block change; counters run.
// RULE22: Capture begins only after the block bit is cleared.
// RULE23: Power-on reset overrides bus reset; pins float until both release.
package vplc_pkg;
  localparam logic [7:0] ADR_PERIPH_CTL = 8'h00;
  localparam logic [7:0] ADR_GFUNC = 8'h04;
  localparam logic [7:0] ADR_GDOUT = 8'h08;
  localparam logic [7:0] ADR_GPIN = 8'h0C;
  localparam logic [7:0] ADR_PORT = 8'h10;
  localparam logic [7:0] ADR_CAPA = 8'h14;
  localparam logic [7:0] ADR_CAPB = 8'h18;
  localparam logic [7:0] ADR_DISP = 8'h1C;
  localparam logic [7:0] ADR_STAT = 8'h20;
  // Port control fields
  localparam int PORT_SRST = 0;
  localparam int PORT_HALT = 1;
  localparam int PORT_DSEL = 2;
  localparam int PORT_CMODE = 4;
  localparam int PORT_DMODE = 8;
  // Capture channel control fields
  localparam int CAP_EN = 0;
  localparam int CAP_RST = 1;
  localparam int CAP_BLK = 2;
  localparam int CAP_FALL = 3;
  localparam int CAP_CNT = 16;
  localparam logic [3:0] CAP_RSTVAL = 4'h4;
  // Status fields
  localparam int STAT_STC = 16;
  localparam int GPIO_W = 22;
  // Capture modes
  localparam logic [2:0] CM_BT656 = 3'h0;
  localparam logic [2:0] CM_YC = 3'h1;
  localparam logic [2:0] CM_RAW8 = 3'h2;
  localparam logic [2:0] CM_RAW16 = 3'h3;
  localparam logic [2:0] CM_XPORT = 3'h4;
  // Display modes
  localparam logic [1:0] DM_BT656 = 2'h0;
  localparam logic [1:0] DM_YC = 2'h1;
  localparam logic [1:0] DM_DUAL = 2'h2;
  localparam logic [1:0] DM_RAW16 = 2'h3;

  typedef enum logic [2:0] {
    ST_HALT = 3'b001,
    ST_SRST = 3'b010,
    ST_RUN = 3'b100
  } vplc_state_t;

  typedef struct packed {
    logic [19:2] data;
    logic [2:0] ctl;
    logic cap_clk;
    logic dclk;
  } vplc_pin_in_t;

  typedef struct packed {
    logic [19:2] data;
    logic [19:2] data_oe_n;
    logic [2:0] ctl;
    logic [2:0] ctl_oe_n;
    logic dclk;
    logic dclk_oe_n;
  } vplc_pin_out_t;

  localparam vplc_pin_out_t PINS_FLOAT = '{data: 18'h0_0000, data_oe_n: 18'h3_FFFF,
    ctl: 3'h0, ctl_oe_n: 3'h7, dclk: 1'b0, dclk_oe_n: 1'b1};

  typedef struct packed {
    logic [15:0] a;
    logic [7:0] b;
    logic a_vld;
    logic b_vld;
  } vplc_cap_t;

  typedef struct packed {
    logic [15:0] a;
    logic [7:0] b;
  } vplc_disp_t;
endpackage

// ---- vplc_top.sv ----
// Video port reset sequencing, Wishbone register slave and lane mapping
`timescale 1ns/1ps
module vplc_top (
  // Clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Port pins
  input wire vplc_pkg::vplc_pin_in_t pins_i,
  output vplc_pkg::vplc_pin_out_t pins_o,
  // Sample streams
  output vplc_pkg::vplc_cap_t cap_o,
  input wire vplc_pkg::vplc_disp_t disp_i
);
  import vplc_pkg::*;

  logic [1:0] por_q;
  logic hard_rst;
  logic port_rst;
  vplc_pin_in_t pin_s1;
  vplc_pin_in_t pin_s2;
  logic cclk_d;
  logic dclk_d;
  logic [1:0] ch_rise;
  logic [1:0] ch_fall;
  logic periph_en;
  logic [GPIO_W-1:0] gpio_func;
  logic [GPIO_W-1:0] gpio_dout;
  vplc_state_t state;
  logic disp_sel;
  logic [2:0] cap_mode;
  logic [1:0] disp_mode;
  logic disp_en;
  logic [15:0] stc_cnt;
  logic [1:0] cap_en;
  logic [1:0] cap_blk;
  logic [1:0] cap_fall;
  logic [1:0] ch_busy;
  logic [1:0] fire;
  logic [15:0] cap_cnt [2];
  logic req;
  logic wr;
  logic grp_ok;
  logic [31:0] rd_val;
  logic [31:0] wd;
  logic halt;
  logic drive;
  vplc_pin_out_t next_pins;

  function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] m;
    m = cur;
    for (int k = 0; k < 4; k++) begin
      if (sel[k]) begin
        m[k*8 +: 8] = nw[k*8 +: 8];
      end
    end
    return m;
  endfunction

  // Power-on reset asserts at once and releases on the clock
  always_ff @(posedge clk_i or posedge por_i) begin
    if (por_i) begin
      por_q <= 2'b11; // RULE6
    end else begin
      por_q <= {por_q[0], 1'b0};
    end
  end

  assign hard_rst = rst_i | por_q[1]; // RULE7 RULE23
  assign port_rst = hard_rst | (state == ST_SRST); // RULE15
  assign halt = (state != ST_RUN);

  // Pin inputs pass two flip-flops
  always_ff @(posedge clk_i or posedge por_i) begin
    if (por_i) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      cclk_d <= 1'b0;
      dclk_d <= 1'b0;
    end else begin
      pin_s1 <= pins_i;
      pin_s2 <= pin_s1;
      cclk_d <= pin_s2.cap_clk;
      dclk_d <= pin_s2.dclk;
    end
  end

  // Video clock edges reach the port only while enabled
  assign ch_rise = {pin_s2.dclk & ~dclk_d, pin_s2.cap_clk & ~cclk_d} & {2{periph_en}}; // RULE10 RULE14
  assign ch_fall = {~pin_s2.dclk & dclk_d, ~pin_s2.cap_clk & cclk_d} & {2{periph_en}}; // RULE10

  // Bus decode; a write lands at the edge where the master sees ack
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & grp_ok;
  assign wd = merge(rd_val, wb_dat_i, wb_sel_i);

  always_comb begin
    grp_ok = periph_en; // RULE12
    rd_val = 32'h0000_0000;
    case (wb_adr_i)
      ADR_PERIPH_CTL: begin
        grp_ok = 1'b1;
        rd_val[0] = periph_en;
      end
      ADR_GFUNC: begin
        grp_ok = 1'b1;
        rd_val[GPIO_W-1:0] = gpio_func;
      end
      ADR_GDOUT: begin
        grp_ok = 1'b1;
        rd_val[GPIO_W-1:0] = gpio_dout;
      end
      ADR_GPIN: begin
        grp_ok = 1'b1;
        rd_val[GPIO_W-1:0] = {pin_s2.dclk, pin_s2.ctl, pin_s2.data};
      end
      ADR_PORT: begin
        rd_val[PORT_SRST] = (state == ST_SRST);
        rd_val[PORT_HALT] = halt;
        rd_val[PORT_DSEL] = disp_sel;
        rd_val[PORT_CMODE +: 3] = cap_mode;
        rd_val[PORT_DMODE +: 2] = disp_mode;
      end
      ADR_CAPA, ADR_CAPB: begin
        if (!ch_busy[wb_adr_i[3]]) begin
          rd_val[CAP_EN] = cap_en[wb_adr_i[3]];
          rd_val[CAP_BLK] = cap_blk[wb_adr_i[3]];
          rd_val[CAP_FALL] = cap_fall[wb_adr_i[3]];
          rd_val[CAP_CNT +: 16] = cap_cnt[wb_adr_i[3]];
        end else begin
          rd_val[CAP_RST] = 1'b1; // RULE20
        end
      end
      ADR_DISP: begin
        rd_val[0] = disp_en;
      end
      ADR_STAT: begin
        rd_val[0] = (state == ST_SRST);
        rd_val[2:1] = ch_busy;
        rd_val[STAT_STC +: 16] = stc_cnt;
      end
      default: begin
        grp_ok = 1'b0;
      end
    endcase
    if (!grp_ok) begin
      rd_val = 32'h0000_0000;
    end
  end

  // Every access is answered one cycle after it is seen
  always_ff @(posedge clk_i or posedge por_i) begin
    if (por_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req; // RULE11
      wb_dat_o <= (req & ~wb_we_i) ? rd_val : 32'h0000_0000;
    end
  end

  // Enable survives a soft reset; GPIO registers do not
  always_ff @(posedge clk_i or posedge por_i) begin
    if (por_i) begin
      periph_en <= 1'b0;
    end else if (hard_rst) begin
      periph_en <= 1'b0; // RULE8
    end else if (wr && wb_adr_i == ADR_PERIPH_CTL) begin
      periph_en <= wd[0];
    end
  end

  always_ff @(posedge clk_i or posedge por_i) begin
    if (por_i) begin
      gpio_func <= '0;
      gpio_dout <= '0;
    end else if (port_rst) begin
      gpio_func <= '0; // RULE8
      gpio_dout <= '0;
    end else if (wr) begin
      if (wb_adr_i == ADR_GFUNC) begin
        gpio_func <= wd[GPIO_W-1:0];
      end
      if (wb_adr_i == ADR_GDOUT) begin
        gpio_dout <= wd[GPIO_W-1:0];
      end
    end
  end

  // Port sequence: halted, soft reset, back to halted, running
  always_ff @(posedge clk_i or posedge por_i) begin
    if (por_i) begin
      state <= ST_HALT;
    end else if (hard_rst) begin
      state <= ST_HALT; // RULE8
    end else if (wr && wb_adr_i == ADR_PORT && wd[PORT_SRST]) begin
      state <= ST_SRST; // RULE15 RULE17
    end else begin
      case (state)
        ST_SRST: begin
          if (ch_rise[0]) begin
            state <= ST_HALT; // RULE9 RULE15
          end
        end
        ST_HALT: begin
          if (wr && wb_adr_i == ADR_PORT && !wd[PORT_HALT]) begin
            state <= ST_RUN; // RULE14
          end
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_HALT;
        end
      endcase
    end
  end

  // Port control fields are frozen once the halt is released
  always_ff @(posedge clk_i or posedge por_i) begin
    if (por_i) begin
      disp_sel <= 1'b0;
      cap_mode <= CM_BT656;
      disp_mode <= DM_BT656;
    end else if (port_rst) begin
      disp_sel <= 1'b0;
      cap_mode <= CM_BT656;
      disp_mode <= DM_BT656;
    end else if (wr && wb_adr_i == ADR_PORT && state == ST_HALT) begin
      disp_sel <= wd[PORT_DSEL]; // RULE14 RULE17
      cap_mode <= wd[PORT_CMODE +: 3];
      disp_mode <= wd[PORT_DMODE +: 2];
    end
  end

  always_ff @(posedge clk_i or posedge por_i) begin
    if (por_i) begin
      disp_en <= 1'b0;
    end else if (port_rst) begin
      disp_en <= 1'b0;
    end else if (wr && wb_adr_i == ADR_DISP) begin
      disp_en <= wd[0];
    end
  end

  // System time counter stops while its clock is gated
  always_ff @(posedge clk_i or posedge por_i) begin
    if (por_i) begin
      stc_cnt <= 16'h0000;
    end else if (port_rst) begin
      stc_cnt <= 16'h0000;
    end else if (periph_en) begin
      stc_cnt <= stc_cnt + 16'h0001; // RULE10
    end
  end

  // Capture channels: channel B takes its clock on the display clock pin
  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic hit;
    assign hit = wr && wb_adr_i[7:2] == (ADR_CAPA[7:2] + 6'(i));
    assign fire[i] = cap_en[i] & ~cap_blk[i] & ~ch_busy[i] & ~halt & ~disp_sel
      & (cap_fall[i] ? ch_fall[i] : ch_rise[i]); // RULE20 RULE22

    always_ff @(posedge clk_i or posedge por_i) begin
      if (por_i) begin
        ch_busy[i] <= 1'b0;
      end else if (port_rst) begin
        ch_busy[i] <= 1'b0;
      end else if (hit && wd[CAP_RST]) begin
        ch_busy[i] <= 1'b1; // RULE19
      end else if (ch_rise[i]) begin
        ch_busy[i] <= 1'b0; // RULE19 RULE20
      end
    end

    always_ff @(posedge clk_i or posedge por_i) begin
      if (por_i) begin
        {cap_fall[i], cap_blk[i], cap_en[i]} <= {CAP_RSTVAL[CAP_FALL], CAP_RSTVAL[CAP_BLK], CAP_RSTVAL[CAP_EN]};
      end else if (port_rst || ch_busy[i]) begin
        {cap_fall[i], cap_blk[i], cap_en[i]} <= {CAP_RSTVAL[CAP_FALL], CAP_RSTVAL[CAP_BLK], CAP_RSTVAL[CAP_EN]}; // RULE20
      end else if (hit && !wd[CAP_RST]) begin
        cap_en[i] <= wd[CAP_EN];
        cap_blk[i] <= wd[CAP_BLK];
        if (!cap_en[i]) begin
          cap_fall[i] <= wd[CAP_FALL]; // RULE21
        end
      end
    end

    always_ff @(posedge clk_i or posedge por_i) begin
      if (por_i) begin
        cap_cnt[i] <= 16'h0000;
      end else if (port_rst || ch_busy[i]) begin
        cap_cnt[i] <= 16'h0000;
      end else if (cap_en[i] && ch_rise[i]) begin
        cap_cnt[i] <= cap_cnt[i] + 16'h0001; // RULE21
      end
    end
  end

  // Lane mapping of captured samples
  always_ff @(posedge clk_i or posedge por_i) begin
    if (por_i) begin
      cap_o <= '0;
    end else if (port_rst) begin
      cap_o <= '0;
    end else begin
      cap_o.a_vld <= fire[0];
      cap_o.b_vld <= fire[1] & (cap_mode == CM_BT656 || cap_mode == CM_RAW8); // RULE1
      if (fire[0]) begin
        if (cap_mode == CM_YC || cap_mode == CM_RAW16) begin
          cap_o.a <= {pin_s2.data[19:12], pin_s2.data[9:2]}; // RULE2
        end else begin
          cap_o.a <= {8'h00, pin_s2.data[9:2]}; // RULE1 RULE2
        end
      end
      if (fire[1]) begin
        cap_o.b <= pin_s2.data[19:12]; // RULE1
      end
    end
  end

  // Pin drive: video lanes over GPIO, floating otherwise
  assign drive = periph_en & ~halt & disp_sel & disp_en;

  always_comb begin
    next_pins.data = gpio_dout[17:0];
    next_pins.data_oe_n = ~gpio_func[17:0]; // RULE13
    next_pins.ctl = gpio_dout[20:18];
    next_pins.ctl_oe_n = ~gpio_func[20:18]; // RULE18
    next_pins.dclk = gpio_dout[21];
    next_pins.dclk_oe_n = ~gpio_func[21];
    if (drive) begin
      next_pins.data[9:2] = disp_i.a[7:0]; // RULE3
      next_pins.data_oe_n[9:2] = 8'h00;
      case (disp_mode)
        DM_YC, DM_RAW16: begin
          next_pins.data[19:12] = disp_i.a[15:8]; // RULE3
          next_pins.data_oe_n[19:12] = 8'h00;
        end
        DM_DUAL: begin
          next_pins.data[19:12] = disp_i.b; // RULE3
          next_pins.data_oe_n[19:12] = 8'h00;
        end
        default: begin
        end
      endcase
    end
    if (periph_en && !halt && disp_sel) begin
      next_pins.dclk = pin_s2.cap_clk; // RULE17
      next_pins.dclk_oe_n = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge por_i) begin
    if (por_i) begin
      pins_o <= PINS_FLOAT; // RULE6 RULE23
    end else if (port_rst) begin
      pins_o <= PINS_FLOAT; // RULE8
    end else begin
      pins_o <= next_pins;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (por_i || rst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_srst_wr;
    wr && wb_adr_i == ADR_PORT && wd[PORT_SRST];
  endsequence

  a_ack_always: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o) // RULE11
    else $error("access not acknowledged");
  a_por_float: assert property (@(posedge clk_i) disable iff (rst_i) por_q[1] |=> pins_o == PINS_FLOAT) // RULE6
    else $error("pins driven during power-on reset");
  a_bus_rst_state: assert property (@(posedge clk_i) disable iff (por_i) // RULE8
    rst_i |=> !periph_en && halt && pins_o == PINS_FLOAT) else $error("bus reset state wrong");
  a_stc_gated: assert property (!periph_en && !port_rst |=> $stable(stc_cnt)) // RULE10
    else $error("time counter ran while gated");
  a_gpio_only: assert property (s_req ##0 (!wb_we_i && !periph_en && wb_adr_i == ADR_PORT) // RULE12
    |=> wb_dat_o == 32'h0000_0000) else $error("port register visible while disabled");
  a_srst_keep: assert property (s_srst_wr ##0 periph_en |=> (state == ST_SRST) && periph_en) // RULE15
    else $error("soft reset lost enable");
  a_srst_clear: assert property ((state == ST_SRST) && ch_rise[0] && !(wr && wb_adr_i == ADR_PORT && wd[PORT_SRST]) // RULE15
    |=> state == ST_HALT) else $error("soft reset did not self-clear");
  a_halt_lock: assert property ((state == ST_RUN) |=> $stable(cap_mode) && $stable(disp_sel)) // RULE17
    else $error("mode changed after halt");
  a_ch_lock: assert property (cap_en[0] && !ch_busy[0] && !port_rst |=> $stable(cap_fall[0])) // RULE21
    else $error("capture setup changed while enabled");
  a_block_nocap: assert property (cap_blk[0] |=> !cap_o.a_vld) else $error("capture while blocked"); // RULE22
  a_ctl_float: assert property (!gpio_func[18] && !port_rst |=> pins_o.ctl_oe_n[0]) // RULE18
    else $error("control pin driven");
  a_lane_8bit: assert property (fire[0] && (cap_mode == CM_BT656 || cap_mode == CM_XPORT) // RULE1
    |=> cap_o.a_vld && cap_o.a[15:8] == 8'h00) else $error("8-bit capture used upper lanes");
endmodule

// ---- vplc_vid_src.sv ----
// Behavioural video source that drives the port's input pins
`timescale 1ns/1ps
module vplc_vid_src (
  // Bench control
  input wire logic run_i,
  input wire logic [17:0] word_i,
  // Port pins
  output vplc_pkg::vplc_pin_in_t pins_o
);
  import vplc_pkg::*;
  logic ck = 1'b0;
  logic [17:0] lanes = 18'h0_0000;
  // Clock only toggles within frames; idle lanes keep changing so stale data never passes
  initial begin
    #1.3;
    forever begin
      #80;
      if (run_i || ck) begin
        ck = ~ck;
        if (!ck) begin
          lanes = word_i;
        end
      end else begin
        lanes = ~lanes;
      end
    end
  end
  assign pins_o = '{data: lanes, ctl: 3'h7, cap_clk: ck, dclk: ck};
endmodule

// ---- vplc_top_tb.sv ----
// Self-checking bench for the video port reset and lane control block
`timescale 1ns/1ps
module vplc_top_tb;
  import vplc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic por_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  vplc_pin_in_t pins_i;
  vplc_pin_in_t src_p;
  vplc_pin_out_t pins_o;
  vplc_cap_t cap_o;
  vplc_disp_t disp_i = '0;
  logic run = 1'b0;
  logic [17:0] word = 18'h0_0000;
  logic [15:0] last_a;
  logic [7:0] last_b;
  logic [31:0] rd;
  int n_fail = 0;
  int checks = 0;
  int na = 0;
  int nb = 0;
  integer seed = 32'h0086_504f;

  vplc_top uut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pins_i(pins_i), .pins_o(pins_o), .cap_o(cap_o), .disp_i(disp_i));
  vplc_vid_src src (.run_i(run), .word_i(word), .pins_o(src_p));

  // Wire level of the two-way pins: the port wins where it drives
  assign pins_i = '{data: (pins_o.data & ~pins_o.data_oe_n) | (src_p.data & pins_o.data_oe_n),
    ctl: (pins_o.ctl & ~pins_o.ctl_oe_n) | (src_p.ctl & pins_o.ctl_oe_n), cap_clk: src_p.cap_clk,
    dclk: pins_o.dclk_oe_n ? src_p.dclk : pins_o.dclk};

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (cap_o.a_vld === 1'b1) begin
      na++;
      last_a = cap_o.a;
    end
    if (cap_o.b_vld === 1'b1) begin
      nb++;
      last_b = cap_o.b;
    end
  end

  task automatic end_sim();
    $display("Counts: %0d checks, %0d mismatches", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input vplc_pin_out_t got, input vplc_pin_out_t exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: pins %h expected %h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle; read data lands in rd
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50)
      n_fail++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdc(input logic [7:0] adr, input logic [31:0] mask, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000);
    chk(rd & mask, exp);
  endtask

  // Poll a self-clearing bit until it reads zero
  task automatic poll(input logic [7:0] adr, input int bitn);
    int n;
    n = 0;
    do begin
      wb(1'b0, adr, 32'h0000_0000);
      n++;
    end while (rd[bitn] !== 1'b0 && n < 40);
  endtask

  task automatic srst();
    wb(1'b1, ADR_PORT, 32'h0000_0001);
    poll(ADR_PORT, PORT_SRST);
    chk(rd, 32'h0000_0002);
    rdc(ADR_PERIPH_CTL, 32'h0000_0001, 32'h0000_0001);
  endtask

  function automatic logic [15:0] exp_a(input logic [2:0] m, input logic [17:0] w);
    if (m == CM_YC || m == CM_RAW16)
      return {w[17:10], w[7:0]};
    return {8'h00, w[7:0]};
  endfunction

  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    end_sim();
  end

  initial begin
    logic [31:0] v;
    logic [2:0] m;
    logic [1:0] dm;
    logic [17:0] oe;
    logic [17:0] ed;
    logic bm;
    int a0;
    int b0;
    int n;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk_pin(pins_o, PINS_FLOAT);
    @(posedge clk_i);
    rdc(ADR_PERIPH_CTL, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc(ADR_PORT, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc(8'h3C, 32'hFFFF_FFFF, 32'h0000_0000);
    v = $random(seed);
    wb(1'b1, ADR_GFUNC, 32'h0003_FFFF);
    wb(1'b1, ADR_GDOUT, v);
    #1;
    chk({14'h0, pins_o.data}, {14'h0, v[17:0]});
    chk({14'h0, pins_o.data_oe_n}, 32'h0000_0000);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk_pin(pins_o, PINS_FLOAT);
    @(posedge clk_i);
    rdc(ADR_GFUNC, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test reset_gpio done");
    run <= 1'b1;
    wb(1'b1, ADR_PERIPH_CTL, 32'h0000_0001);
    rdc(ADR_PORT, 32'hFFFF_FFFF, 32'h0000_0002);
    rdc(ADR_CAPA, 32'h0000_FFFF, {28'h0, CAP_RSTVAL});
    for (int i = 0; i < 5; i++) begin
      m = 3'(i);
      srst();
      wb(1'b1, ADR_PORT, {25'h0, m, 4'h0});
      wb(1'b1, ADR_CAPA, 32'h0000_0001);
      wb(1'b1, ADR_CAPB, 32'h0000_0001);
      bm = (m == CM_BT656 || m == CM_RAW8);
      for (int k = 0; k < 3; k++) begin
        word <= 18'($random(seed));
        a0 = na;
        b0 = nb;
        n = 0;
        while ((na < a0 + 2 || (bm && nb < b0 + 2)) && n < 300) begin
          @(posedge clk_i);
          n++;
        end
        if (n >= 300)
          n_fail++;
        chk({16'h0, last_a}, {16'h0, exp_a(m, word)});
        if (bm)
          chk({24'h0, last_b}, {24'h0, word[17:10]});
      end
      $display("test capture mode %0d done", i);
    end
    wb(1'b1, ADR_PORT, 32'h0000_0030);
    rdc(ADR_PORT, 32'h0000_FFFF, 32'h0000_0040);
    wb(1'b1, ADR_CAPA, 32'h0000_0009);
    rdc(ADR_CAPA, 32'h0000_FFFF, 32'h0000_0001);
    wb(1'b1, ADR_CAPA, 32'h0000_0005);
    @(posedge clk_i);
    a0 = na;
    repeat (100) @(posedge clk_i);
    chk(na, a0);
    wb(1'b1, ADR_CAPA, 32'h0000_0003);
    poll(ADR_CAPA, CAP_RST);
    chk(rd & 32'h0000_FFFF, {28'h0, CAP_RSTVAL});
    rdc(ADR_CAPB, 32'h0000_FFFF, 32'h0000_0001);
    a0 = na;
    repeat (100) @(posedge clk_i);
    chk(na, a0);
    $display("test capture control done");
    for (int i = 0; i < 4; i++) begin
      dm = 2'(i);
      srst();
      wb(1'b1, ADR_PORT, {22'h0, dm, 8'h04});
      wb(1'b1, ADR_DISP, 32'h0000_0001);
      for (int k = 0; k < 3; k++) begin
        disp_i <= {16'($random(seed)), 8'($random(seed))};
        repeat (3) @(posedge clk_i);
        #1;
        oe = {(dm != DM_BT656) ? 8'h00 : 8'hFF, 10'h300};
        ed = {(dm == DM_DUAL) ? disp_i.b : disp_i.a[15:8], 2'b00, disp_i.a[7:0]};
        chk({14'h0, pins_o.data_oe_n}, {14'h0, oe});
        chk({14'h0, pins_o.data & ~oe}, {14'h0, ed & ~oe});
        chk({29'h0, pins_o.ctl_oe_n}, 32'h0000_0007);
        chk({31'h0, pins_o.dclk_oe_n}, 32'h0000_0000);
        @(posedge clk_i);
      end
      $display("test display mode %0d done", i);
    end
    @(posedge clk_i);
    por_i <= 1'b1;
    rst_i <= 1'b1;
    #1;
    chk_pin(pins_o, PINS_FLOAT);
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk_pin(pins_o, PINS_FLOAT);
    @(posedge clk_i);
    por_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rdc(ADR_PERIPH_CTL, 32'hFFFF_FFFF, 32'h0000_0000);
    #1;
    chk_pin(pins_o, PINS_FLOAT);
    $display("test power_on done");
    end_sim();
  end
endmodule
